// *** hdl/frame_builder_params.svh ***
// Constants for the touch feedback frame builder
// How it works
// RQ1: A reply frame goes into the send buffer whenever a request is answered or a touch event gives feedback.
// RQ2: Every frame starts with escape byte 1B, then three identifier bytes, then the parameters at their widths.
// RQ3: Parameters go out as raw binary, except replies defined as character strings.
// RQ4: Multi-byte parameters go out least significant byte first and the host rebuilds them in that order.
// RQ5: The text box content reply is 53 45 55, a 16-bit object number, then 16-bit characters ended by zero.
// RQ6: The text box content reply is sent only when the bound keyboard delivers key code 13.
// RQ7: The button state reply is 54 51 53, object number and state, 1 released and 2 pressed.
// RQ8: Touch replies go out only for press, release or drag events enabled per object; all zero mutes them.
// RQ9: The radio group reply ends in 52, carries active switch and group number, sent on every change.
// RQ10: The keyboard key reply ends in 4B, carries keyboard and key code, only when not bound to a text box.
// RQ11: The bar value reply ends in 49 and carries object number then new value.
// RQ12: The menu entry reply ends in 4D and carries menu object number then selected index.
// RQ13: The combo entry reply ends in 43 and carries object number then selected index.
// RQ14: Restart option decodes 0 normal, 1 test, 2 skip power-on macro, 3 skip defaults, 4 boot menu, 5 reserved.
// RQ15: Each frame enters the send buffer whole, so bytes of two replies never interleave.
`ifndef FRAME_BUILDER_PARAMS_SVH
`define FRAME_BUILDER_PARAMS_SVH
`define ESC_BYTE 8'h1B
`define ID_T_BYTE 8'h54
`define ID_Q_BYTE 8'h51
`define ID_TB0 8'h53
`define ID_TB1 8'h45
`define ID_TB2 8'h55
`define ID_BUTTON 8'h53
`define ID_RADIO 8'h52
`define ID_KEY 8'h4B
`define ID_BAR 8'h49
`define ID_MENU 8'h4D
`define ID_COMBO 8'h43
`define ENTER_CODE 16'h000D
`define STATE_RELEASED 16'h0001
`define STATE_PRESSED 16'h0002
`define EV_PRESS_BIT 0
`define EV_RELEASE_BIT 1
`define EV_DRAG_BIT 2
`define CFG_RESET 3'h0
`define TEXT_DEPTH 16
`define TEXT_IDX_W 4
`define RESTART_DEFAULT 3'h0
`endif

// *** hdl/frame_builder_pkg.sv ***
// Types for the touch feedback frame builder
package frame_builder_pkg;
   typedef enum logic [2:0] {
      REPLY_BUTTON = 3'b000,
      REPLY_RADIO = 3'b001,
      REPLY_KEY = 3'b010,
      REPLY_BAR = 3'b011,
      REPLY_MENU = 3'b100,
      REPLY_COMBO = 3'b101
   } reply_kind_t;

   typedef enum logic [1:0] {
      EV_PRESS = 2'b00,
      EV_RELEASE = 2'b01,
      EV_DRAG = 2'b10
   } touch_event_t;

   typedef enum logic [2:0] {
      RESTART_NORMAL = 3'b000,
      RESTART_TEST = 3'b001,
      RESTART_NO_MACRO = 3'b010,
      RESTART_NO_DEFAULTS = 3'b011,
      RESTART_BOOT_MENU = 3'b100,
      RESTART_RESERVED = 3'b101
   } restart_option_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_PARAM = 3'b010,
      ST_TEXT = 3'b011,
      ST_TERM = 3'b100
   } build_state_t;

   typedef struct packed {
      reply_kind_t kind;
      touch_event_t evt;
      logic [15:0] object_number;
      logic [15:0] value;
   } touch_req_t;

   typedef struct packed {
      logic [15:0] keyboard_object;
      logic [15:0] text_box_object;
      logic bound_to_text_box;
      logic [15:0] key_code;
   } key_req_t;
endpackage : frame_builder_pkg

// *** hdl/frame_skid_buffer.sv ***
// Two-entry byte buffer between frame builder and send buffer
`timescale 1ns/1ps
module frame_skid_buffer (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   logic [7:0] mem_q [2];
   logic [7:0] mem_d [2];
   logic rd_q;
   logic wr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_q != 2'd2);
   assign out_valid_o = (cnt_q != 2'd0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_entry
         assign mem_d[g] = (push && (wr_q == 1'(g))) ? in_data_i : mem_q[g];
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               mem_q[g] <= 8'h00;
            end else begin
               mem_q[g] <= mem_d[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         rd_q <= rd_q ^ pop;
         wr_q <= wr_q ^ push;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : frame_skid_buffer

// *** hdl/touch_feedback_frame_builder.sv ***
// Reply frame builder for touch and text box feedback
`timescale 1ns/1ps
`include "frame_builder_params.svh"
module touch_feedback_frame_builder (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Touch reply request
   input wire logic touch_valid_i,
   output logic touch_ready_o,
   input wire frame_builder_pkg::touch_req_t touch_req_i,
   // Keyboard key event
   input wire logic key_valid_i,
   output logic key_ready_o,
   input wire frame_builder_pkg::key_req_t key_req_i,
   // Text box character store
   input wire logic text_wr_i,
   input wire logic text_clear_i,
   input wire logic [15:0] text_char_i,
   // Report configuration per object slot
   input wire logic cfg_wr_i,
   input wire logic [3:0] cfg_slot_i,
   input wire logic [15:0] cfg_object_i,
   input wire logic [2:0] cfg_events_i,
   // Restart command option
   input wire logic restart_valid_i,
   input wire logic [2:0] restart_option_i,
   output logic restart_normal_o,
   output logic restart_test_o,
   output logic restart_no_macro_o,
   output logic restart_no_defaults_o,
   output logic restart_boot_menu_o,
   output logic restart_reserved_o,
   // Send buffer byte stream
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o,
   output logic busy_o
);
   localparam int SLOTS = 16;

   frame_builder_pkg::build_state_t state_q;
   frame_builder_pkg::build_state_t state_d;
   logic [7:0] id2_q;
   logic [`TEXT_IDX_W:0] txt_n_q;
   logic [1:0] head_cnt_q;
   logic [1:0] par_cnt_q;
   logic [15:0] p0_q;
   logic [15:0] p1_q;
   logic text_frame_q;
   logic [`TEXT_IDX_W-1:0] txt_rd_q;
   logic [`TEXT_IDX_W:0] txt_len_q;
   logic [15:0] text_mem_q [`TEXT_DEPTH];
   logic [15:0] cfg_obj_q [SLOTS];
   logic [2:0] cfg_ev_q [SLOTS];
   logic [15:0] radio_last_q;
   logic radio_seen_q;
   logic [1:0] char_byte_q;

   logic buf_ready;
   logic byte_valid;
   logic [7:0] byte_data;
   logic byte_take;
   logic idle;
   logic [SLOTS-1:0] slot_hit;
   logic [2:0] ev_mask;
   logic ev_allowed;
   logic radio_changed;
   logic touch_send;
   logic touch_take;
   logic key_enter;
   logic key_send;
   logic key_take;
   logic [7:0] last_id;
   logic [7:0] head_byte;
   logic [15:0] cur_par;
   logic [7:0] par_byte;
   logic [15:0] cur_char;
   logic [7:0] char_byte;
   logic text_last;
   logic kind_ok;
   logic evt_ok;
   logic [15:0] touch_p1;
   logic frame_start;
   logic radio_take;
   logic [5:0] restart_hit;

   assign idle = (state_q == frame_builder_pkg::ST_IDLE);
   assign busy_o = !idle;

   genvar s;
   generate
      for (s = 0; s < SLOTS; s++) begin : g_slot
         assign slot_hit[s] = (cfg_obj_q[s] == touch_req_i.object_number) && (cfg_ev_q[s] != `CFG_RESET);
         always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               cfg_obj_q[s] <= 16'h0000;
               cfg_ev_q[s] <= `CFG_RESET;
            end else if (cfg_wr_i && (cfg_slot_i == 4'(s))) begin
               cfg_obj_q[s] <= cfg_object_i;
               cfg_ev_q[s] <= cfg_events_i;
            end
         end
      end
   endgenerate

   // Matching slots OR their masks; an unconfigured object stays muted
   always_comb begin
      ev_mask = 3'h0;
      for (int i = 0; i < SLOTS; i++) begin
         if (slot_hit[i]) begin
            ev_mask = ev_mask | cfg_ev_q[i];
         end
      end
   end

   // Unused kind and event codes never open a frame
   assign kind_ok = (touch_req_i.kind <= frame_builder_pkg::REPLY_COMBO);
   assign evt_ok = (touch_req_i.evt != 2'h3);
   // RQ8 event enable gate
   assign ev_allowed = evt_ok && ev_mask[touch_req_i.evt];
   // RQ9 change detect
   assign radio_changed = !radio_seen_q || (radio_last_q != touch_req_i.object_number);
   assign touch_send = kind_ok && ev_allowed &&
      ((touch_req_i.kind != frame_builder_pkg::REPLY_RADIO) || radio_changed);
   assign radio_take = touch_take && touch_send && (touch_req_i.kind == frame_builder_pkg::REPLY_RADIO);
   // Requests are taken only between frames, keyboard first
   assign key_take = key_valid_i && idle;
   assign touch_take = touch_valid_i && idle && !key_valid_i;
   assign key_ready_o = idle;
   assign touch_ready_o = idle && !key_valid_i;
   // RQ6 enter triggers text box
   assign key_enter = key_req_i.bound_to_text_box && (key_req_i.key_code == `ENTER_CODE);
   // RQ10 unbound keyboards only
   assign key_send = !key_req_i.bound_to_text_box;
   // RQ1 any reply opens a frame
   assign frame_start = (key_take && (key_enter || key_send)) || (touch_take && touch_send);
   // RQ7 button state follows the event, not the caller's value
   assign touch_p1 = (touch_req_i.kind != frame_builder_pkg::REPLY_BUTTON) ? touch_req_i.value :
      (touch_req_i.evt == frame_builder_pkg::EV_RELEASE) ? `STATE_RELEASED : `STATE_PRESSED;

   // RQ7 RQ9 RQ11 RQ12 RQ13 identifier bytes
   assign last_id =
      (touch_req_i.kind == frame_builder_pkg::REPLY_BUTTON) ? `ID_BUTTON :
      (touch_req_i.kind == frame_builder_pkg::REPLY_RADIO) ? `ID_RADIO :
      (touch_req_i.kind == frame_builder_pkg::REPLY_KEY) ? `ID_KEY :
      (touch_req_i.kind == frame_builder_pkg::REPLY_BAR) ? `ID_BAR :
      (touch_req_i.kind == frame_builder_pkg::REPLY_MENU) ? `ID_MENU : `ID_COMBO;

   // RQ2 escape then identifier
   assign head_byte =
      (head_cnt_q == 2'd0) ? `ESC_BYTE :
      (head_cnt_q == 2'd1) ? (text_frame_q ? `ID_TB0 : `ID_T_BYTE) :
      (head_cnt_q == 2'd2) ? (text_frame_q ? `ID_TB1 : `ID_Q_BYTE) : id2_q;

   // RQ3 RQ4 raw binary, low byte first
   assign cur_par = par_cnt_q[1] ? p1_q : p0_q;
   assign par_byte = par_cnt_q[0] ? cur_par[15:8] : cur_par[7:0];
   // RQ5 16-bit characters, low byte first
   assign cur_char = text_mem_q[txt_rd_q];
   assign char_byte = char_byte_q[0] ? cur_char[15:8] : cur_char[7:0];
   // Length is latched at take, so a clear during the frame cannot run the reader off the end
   assign text_last = ({1'b0, txt_rd_q} == txt_n_q - 5'd1);

   always_comb begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
      case (state_q)
         frame_builder_pkg::ST_HEAD: begin
            byte_valid = 1'b1;
            byte_data = head_byte;
         end
         frame_builder_pkg::ST_PARAM: begin
            byte_valid = 1'b1;
            byte_data = par_byte;
         end
         frame_builder_pkg::ST_TEXT: begin
            byte_valid = 1'b1;
            byte_data = char_byte;
         end
         // RQ5 zero terminator
         frame_builder_pkg::ST_TERM: begin
            byte_valid = 1'b1;
            byte_data = 8'h00;
         end
         default: begin
            byte_valid = 1'b0;
            byte_data = 8'h00;
         end
      endcase
   end
   assign byte_take = byte_valid && buf_ready;

   // RQ15 one frame at a time
   always_comb begin
      state_d = state_q;
      case (state_q)
         frame_builder_pkg::ST_IDLE: begin
            // RQ1 start a frame
            if (frame_start) begin
               state_d = frame_builder_pkg::ST_HEAD;
            end
         end
         frame_builder_pkg::ST_HEAD: begin
            if (byte_take && (head_cnt_q == 2'd3)) begin
               state_d = frame_builder_pkg::ST_PARAM;
            end
         end
         frame_builder_pkg::ST_PARAM: begin
            if (byte_take && text_frame_q && (par_cnt_q == 2'd1)) begin
               state_d = (txt_n_q == 5'd0) ? frame_builder_pkg::ST_TERM : frame_builder_pkg::ST_TEXT;
            end else if (byte_take && (par_cnt_q == 2'd3)) begin
               state_d = frame_builder_pkg::ST_IDLE;
            end
         end
         frame_builder_pkg::ST_TEXT: begin
            if (byte_take && char_byte_q[0] && text_last) begin
               state_d = frame_builder_pkg::ST_TERM;
            end
         end
         frame_builder_pkg::ST_TERM: begin
            if (byte_take && char_byte_q[0]) begin
               state_d = frame_builder_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = frame_builder_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q <= frame_builder_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Capture frame contents when a request is taken
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         id2_q <= 8'h00;
         txt_n_q <= '0;
         p0_q <= 16'h0000;
         p1_q <= 16'h0000;
         text_frame_q <= 1'b0;
      end else if (key_take && key_enter) begin
         id2_q <= `ID_TB2;
         txt_n_q <= txt_len_q;
         text_frame_q <= 1'b1;
         p0_q <= key_req_i.text_box_object;
         p1_q <= 16'h0000;
      end else if (key_take && key_send) begin
         id2_q <= `ID_KEY;
         text_frame_q <= 1'b0;
         p0_q <= key_req_i.keyboard_object;
         p1_q <= key_req_i.key_code;
      end else if (touch_take && touch_send) begin
         id2_q <= last_id;
         text_frame_q <= 1'b0;
         p0_q <= touch_req_i.object_number;
         p1_q <= touch_p1;
      end
   end

   // Byte counters within a frame
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || idle) begin
         head_cnt_q <= 2'd0;
         par_cnt_q <= 2'd0;
         char_byte_q <= 2'd0;
         txt_rd_q <= '0;
      end else if (byte_take) begin
         if (state_q == frame_builder_pkg::ST_HEAD) begin
            head_cnt_q <= head_cnt_q + 2'd1;
         end else if (state_q == frame_builder_pkg::ST_PARAM) begin
            par_cnt_q <= par_cnt_q + 2'd1;
         end else begin
            char_byte_q <= {1'b0, ~char_byte_q[0]};
            if ((state_q == frame_builder_pkg::ST_TEXT) && char_byte_q[0] && !text_last) begin
               txt_rd_q <= txt_rd_q + 1'b1;
            end
         end
      end
   end

   // Text box characters; full store drops extra characters
   // Writes are ignored unless idle so a frame never reads a half-written store
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || text_clear_i) begin
         txt_len_q <= '0;
      end else if (text_wr_i && idle && (txt_len_q != 5'd16)) begin
         text_mem_q[txt_len_q[`TEXT_IDX_W-1:0]] <= text_char_i;
         txt_len_q <= txt_len_q + 5'd1;
      end
   end

   // RQ9 remember active switch
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         radio_last_q <= 16'h0000;
         radio_seen_q <= 1'b0;
      end else if (radio_take) begin
         radio_last_q <= touch_req_i.object_number;
         radio_seen_q <= 1'b1;
      end
   end

   // RQ14 restart decode; options 6 and 7 give no pulse
   assign restart_hit[0] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_NORMAL);
   assign restart_hit[1] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_TEST);
   assign restart_hit[2] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_NO_MACRO);
   assign restart_hit[3] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_NO_DEFAULTS);
   assign restart_hit[4] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_BOOT_MENU);
   assign restart_hit[5] = restart_valid_i && (restart_option_i == frame_builder_pkg::RESTART_RESERVED);
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         restart_normal_o <= 1'b0;
         restart_test_o <= 1'b0;
         restart_no_macro_o <= 1'b0;
         restart_no_defaults_o <= 1'b0;
         restart_boot_menu_o <= 1'b0;
         restart_reserved_o <= 1'b0;
      end else begin
         restart_normal_o <= restart_hit[0];
         restart_test_o <= restart_hit[1];
         restart_no_macro_o <= restart_hit[2];
         restart_no_defaults_o <= restart_hit[3];
         restart_boot_menu_o <= restart_hit[4];
         restart_reserved_o <= restart_hit[5];
      end
   end

   // RQ15 stall keeps bytes in order
   frame_skid_buffer u_buf (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(byte_valid),
      .in_ready_o(buf_ready),
      .in_data_i(byte_data),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );
endmodule : touch_feedback_frame_builder

// *** verif/frame_builder_props.sv ***
// Concurrent checks on the frame builder ports
`timescale 1ns/1ps
module frame_builder_props (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic touch_valid_i,
   input wire logic touch_ready_o,
   input wire logic key_valid_i,
   input wire logic key_ready_o,
   input wire logic restart_valid_i,
   input wire logic [2:0] restart_option_i,
   input wire logic restart_normal_o,
   input wire logic restart_test_o,
   input wire logic restart_no_macro_o,
   input wire logic restart_no_defaults_o,
   input wire logic restart_boot_menu_o,
   input wire logic restart_reserved_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] tx_data_o,
   input wire logic busy_o
);
   wire logic [5:0] rvec;
   assign rvec = {restart_reserved_o, restart_boot_menu_o, restart_no_defaults_o,
      restart_no_macro_o, restart_test_o, restart_normal_o};
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Only a frame opened on an empty buffer shows its first byte one cycle after busy_o rises
   sequence s_start;
      $rose(busy_o) && !tx_valid_o;
   endsequence
   sequence s_esc_taken;
      s_start ##1 tx_ready_i;
   endsequence
   sequence s_touch_flow;
      touch_valid_i && touch_ready_o && !tx_valid_o ##1 (busy_o && tx_ready_i) [*8];
   endsequence
   a_esc_first: assert property (s_start |=> tx_valid_o && tx_data_o == 8'h1B)
      else $error("frame does not open with escape byte");
   a_id_second: assert property (s_esc_taken |=> tx_valid_o && (tx_data_o == 8'h54 || tx_data_o == 8'h53))
      else $error("escape byte not followed by identifier");
   a_busy_blocks: assert property (busy_o |-> !touch_ready_o && !key_ready_o)
      else $error("request accepted while frame in progress");
   a_key_first: assert property (key_valid_i |-> !touch_ready_o)
      else $error("touch accepted beside key request");
   a_hold_stall: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("byte changed while host stalled");
   a_touch_len: assert property (s_touch_flow |=> !busy_o)
      else $error("touch frame not eight bytes long");
   a_restart_one: assert property (restart_valid_i && restart_option_i < 3'h6
      |=> rvec == (6'h01 << $past(restart_option_i)))
      else $error("restart option decoded wrongly");
   a_restart_none: assert property (!restart_valid_i || restart_option_i > 3'h5 |=> rvec == 6'h00)
      else $error("restart pulse without valid option");
endmodule : frame_builder_props

bind touch_feedback_frame_builder frame_builder_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .touch_valid_i(touch_valid_i), .touch_ready_o(touch_ready_o), .key_valid_i(key_valid_i),
   .key_ready_o(key_ready_o), .restart_valid_i(restart_valid_i), .restart_option_i(restart_option_i),
   .restart_normal_o(restart_normal_o), .restart_test_o(restart_test_o), .restart_no_macro_o(restart_no_macro_o),
   .restart_no_defaults_o(restart_no_defaults_o), .restart_boot_menu_o(restart_boot_menu_o),
   .restart_reserved_o(restart_reserved_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .tx_data_o(tx_data_o), .busy_o(busy_o));

// *** verif/host_byte_sink.sv ***
// Host model draining the send buffer, fast or slow
`timescale 1ns/1ps
module host_byte_sink (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic stall_i,
   input wire logic valid_i,
   input wire logic [7:0] data_i,
   output logic ready_o
);
   logic [1:0] phase_q;
   logic [7:0] got[$];
   // Slow host takes one byte in four, so the buffer fills
   assign ready_o = !stall_i || phase_q == 2'h3;
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
      if (rst_n_i && valid_i && ready_o) begin
         got.push_back(data_i);
      end
   end
endmodule : host_byte_sink

// *** verif/test_touch_feedback_frame_builder.sv ***
// Self-checking bench for the frame builder
`timescale 1ns/1ps
module test_touch_feedback_frame_builder;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tv = 1'b0, kv = 1'b0, twr = 1'b0, tclr = 1'b0, cwr = 1'b0, rv = 1'b0, stall = 1'b0;
   logic [15:0] tchar = 16'h0000, cobj = 16'h0000;
   logic [3:0] cslot = 4'h0;
   logic [2:0] cev = 3'h0, ropt = 3'h0;
   frame_builder_pkg::touch_req_t treq = '0;
   frame_builder_pkg::key_req_t kreq = '0;
   logic tr, kr, txv, txr, busy;
   logic [7:0] txd;
   logic [5:0] rvec;
   logic [7:0] exp[$];
   int fails = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   touch_feedback_frame_builder u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .touch_valid_i(tv), .touch_ready_o(tr),
      .touch_req_i(treq), .key_valid_i(kv), .key_ready_o(kr), .key_req_i(kreq), .text_wr_i(twr),
      .text_clear_i(tclr), .text_char_i(tchar), .cfg_wr_i(cwr), .cfg_slot_i(cslot), .cfg_object_i(cobj),
      .cfg_events_i(cev), .restart_valid_i(rv), .restart_option_i(ropt), .restart_normal_o(rvec[0]),
      .restart_test_o(rvec[1]), .restart_no_macro_o(rvec[2]), .restart_no_defaults_o(rvec[3]),
      .restart_boot_menu_o(rvec[4]), .restart_reserved_o(rvec[5]), .tx_valid_o(txv), .tx_ready_i(txr),
      .tx_data_o(txd), .busy_o(busy));
   host_byte_sink u_sink (.core_clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .valid_i(txv), .data_i(txd),
      .ready_o(txr));
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   task chk_byte(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk_byte
   task tick;
      @(posedge clk);
      #1;
   endtask : tick
   task e16(input logic [15:0] v);
      exp.push_back(v[7:0]);
      exp.push_back(v[15:8]);
   endtask : e16
   task e_head(input logic [7:0] last);
      exp.push_back(8'h1B);
      exp.push_back(8'h54);
      exp.push_back(8'h51);
      exp.push_back(last);
   endtask : e_head
   task handshake(input logic is_key);
      int i;
      i = 0;
      while (!(is_key ? kr : tr) && i < 50) begin
         tick();
         i++;
      end
      if (i == 50) begin
         fails++;
         summarize();
      end
      tick();
      tv = 1'b0;
      kv = 1'b0;
      tick();
   endtask : handshake
   task touch(input logic [2:0] k, input logic [1:0] e, input logic [15:0] o, input logic [15:0] v);
      treq = {k, e, o, v};
      tv = 1'b1;
      handshake(1'b0);
   endtask : touch
   task key(input logic b, input logic [15:0] c);
      kreq = {16'h0300, 16'h0400, b, c};
      kv = 1'b1;
      handshake(1'b1);
   endtask : key
   task cfg(input logic [3:0] s, input logic [15:0] o, input logic [2:0] e);
      cslot = s;
      cobj = o;
      cev = e;
      cwr = 1'b1;
      tick();
      cwr = 1'b0;
      tick();
   endtask : cfg
   task finish_frame;
      int i;
      i = 0;
      while ((busy !== 1'b0 || txv !== 1'b0) && i < 400) begin
         tick();
         i++;
      end
      if (i == 400) begin
         fails++;
         summarize();
      end
      chk_byte(8'(u_sink.got.size()), 8'(exp.size()));
      foreach (exp[j]) chk_byte(u_sink.got[j], exp[j]);
      u_sink.got.delete();
      exp.delete();
   endtask : finish_frame
   task t_restart;
      rv = 1'b1;
      for (int o = 0; o < 8; o++) begin
         ropt = 3'(o);
         tick();
         chk_byte({2'b00, rvec}, (o < 6) ? 8'(8'h01 << o) : 8'h00);
      end
      rv = 1'b0;
      tick();
   endtask : t_restart
   task t_gating;
      touch(3'h0, 2'h0, 16'h0102, 16'h0002);
      finish_frame();
      cfg(4'h0, 16'h0102, 3'h1);
      touch(3'h0, 2'h0, 16'h0102, 16'h0002);
      e_head(8'h53);
      e16(16'h0102);
      e16(16'h0002);
      finish_frame();
      touch(3'h0, 2'h1, 16'h0102, 16'h0001);
      finish_frame();
      cfg(4'h0, 16'h0102, 3'h2);
      touch(3'h0, 2'h1, 16'h0102, 16'h0007);
      e_head(8'h53);
      e16(16'h0102);
      e16(16'h0001);
      finish_frame();
      cfg(4'h0, 16'h0102, 3'h0);
      touch(3'h0, 2'h0, 16'h0102, 16'h0002);
      finish_frame();
   endtask : t_gating
   task t_kinds;
      logic [7:0] ids [4] = '{8'h4B, 8'h49, 8'h4D, 8'h43};
      cfg(4'h1, 16'h1B2C, 3'h7);
      for (int i = 0; i < 4; i++) begin
         touch(3'(i + 2), 2'h2, 16'h1B2C, 16'hA55A + 16'(i));
         e_head(ids[i]);
         e16(16'h1B2C);
         e16(16'hA55A + 16'(i));
         finish_frame();
      end
   endtask : t_kinds
   task t_radio;
      cfg(4'h2, 16'h0505, 3'h7);
      cfg(4'h3, 16'h0606, 3'h7);
      touch(3'h1, 2'h0, 16'h0505, 16'h0009);
      e_head(8'h52);
      e16(16'h0505);
      e16(16'h0009);
      finish_frame();
      touch(3'h1, 2'h0, 16'h0505, 16'h0009);
      finish_frame();
      touch(3'h1, 2'h0, 16'h0606, 16'h0009);
      e_head(8'h52);
      e16(16'h0606);
      e16(16'h0009);
      finish_frame();
   endtask : t_radio
   task t_key;
      key(1'b0, 16'h0041);
      e_head(8'h4B);
      e16(16'h0300);
      e16(16'h0041);
      finish_frame();
      key(1'b1, 16'h0041);
      finish_frame();
      key(1'b1, 16'h000D);
      exp = '{8'h1B, 8'h53, 8'h45, 8'h55, 8'h00, 8'h04, 8'h00, 8'h00};
      finish_frame();
      tclr = 1'b1;
      tick();
      tclr = 1'b0;
      twr = 1'b1;
      tchar = 16'h0041;
      tick();
      tchar = 16'h1234;
      tick();
      twr = 1'b0;
      key(1'b1, 16'h000D);
      exp = '{8'h1B, 8'h53, 8'h45, 8'h55, 8'h00, 8'h04, 8'h41, 8'h00, 8'h34, 8'h12, 8'h00, 8'h00};
      finish_frame();
   endtask : t_key
   task t_stall;
      stall = 1'b1;
      for (int i = 0; i < 2; i++) begin
         touch(3'h3, 2'h0, 16'h1B2C, 16'h0F00 + 16'(i));
         e_head(8'h49);
         e16(16'h1B2C);
         e16(16'h0F00 + 16'(i));
      end
      finish_frame();
      stall = 1'b0;
   endtask : t_stall
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_restart();
      t_gating();
      t_kinds();
      t_radio();
      t_key();
      t_stall();
      summarize();
   end
endmodule : test_touch_feedback_frame_builder
